//--- hsc_host.sv
// Two-wire host model for the register port of the capture block.
// Assumes the bench resolves SDA with a pull-up from sda_rel and the device enable.
`timescale 1ns/1ns
`default_nettype none
module hsc_host #(
  parameter logic [6:0] ADDR = 7'h30
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  logic [7:0] got[$]; // Bytes of the last read
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Moves land on falling edges, clear of the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit; SCL low and high four clocks each, above the three-clock minimum
  task automatic bitx(input logic b, output logic r);
    sda_rel = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // Start, also used as repeated start
  task automatic start();
    sda_rel = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_rel = 1'b0;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_rel = 1'b1;
    tick(3);
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r); // Acknowledge slot, released by the host
  endtask
  // A released bit on the last byte is the NACK that ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    wbyte({ADDR, 1'b0});
    wbyte(p);
    wbyte(d);
    stop();
  endtask
  // Block read of n bytes from pointer p
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] d;
    got.delete();
    start();
    wbyte({ADDR, 1'b0});
    wbyte(p);
    start();
    wbyte({ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      rbyte(k == n - 1, d);
      got.push_back(d);
    end
    stop();
  endtask
endmodule
`default_nettype wire

//--- hsc_pkg.sv
// Constants, register map and carrier types for the hot-swap capture and fault policy block.
// Assumes one 25 MHz clock and a two-wire register port sampled synchronously.
// Notes on behaviour
// - Per-buffer resolution bit, 1 high byte, reset ones.
// - Full resolution: upper eight bits, then two LSBs.
// - High-byte mode: one byte per sample.
// - Keep storing stop-delay samples after shutdown.
// - Stop delay ranges zero to fifty samples.
// - Stop delay resets to twenty-five.
// - Fault shutdown follows latched or retry policy.
// - Policy pin low latches, high retries.
// - Policy pin sampled once, shown status bit six.
// - Retry restarts every 200 ms.
// - Latched channel restarts on enable toggle.
// - Unlocked force bit enables channel regardless.
// - Forced channel never shuts down on faults.
// - Force bit sets need key A5.
// - Fault shutdown stops recording after delay.
// - Buffers read as block at four bases.
package hsc_pkg;
  localparam logic [7:0] OFS_STAT3 = 8'h34;   // Third status register
  localparam logic [7:0] OFS_KEY = 8'h39;     // Force-on key
  localparam logic [7:0] OFS_FORCE = 8'h3a;   // force_on_control
  localparam logic [7:0] OFS_RES = 8'h3f;     // buffer_resolution_select
  localparam logic [7:0] OFS_DLY = 8'h40;     // buffer_stop_delay
  localparam logic [7:0] OFS_BUF0 = 8'h46;    // first_channel_voltage_buffer_base
  localparam logic [7:0] OFS_BUF3 = 8'h49;    // Last buffer base
  localparam logic [3:0] RES_RST = 4'hf;
  localparam logic [5:0] DLY_RST = 6'h19;
  localparam logic [5:0] DLY_MAX = 6'h32;
  localparam logic [1:0] FORCE_RST = 2'h0;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] KEY_UNLOCK = 8'ha5;
  localparam int STAT3_RETRY_BIT = 6;
  localparam logic [5:0] HIST_LAST = 6'h31;   // Index of the fiftieth sample
  localparam logic [5:0] HIST_LEN = 6'h32;
  localparam int CLK_HZ = 25_000_000;
  localparam int RETRY_MS = 200;
  localparam int RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
  // One conversion result with its strobe
  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } hsc_smp_t;
  // Register port states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_A = 3'h3,
    ST_WR = 3'h2,
    ST_ACK_W = 3'h6,
    ST_RD = 3'h7,
    ST_ACK_R = 3'h5
  } hsc_st_t;
endpackage

//--- hsc_top.sv
// History capture read-out, stop delay, restart policy and force-on for two channels.
// Assumes SCL/SDA and all other inputs are already synchronous to MCLK.
`timescale 1ns/1ns
`default_nettype none

// Byte FIFO; depth must be a power of two
module hsc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];         // Storage words
  logic [AW:0] wp_q, wp_d;       // Write pointer with wrap bit
  logic [AW:0] rp_q, rp_d;       // Read pointer with wrap bit
  logic push, pop;

  // Pointer update; flush drops everything held
  always_comb begin
    in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    out_valid = (wp_q != rp_q);
    out_data = mem[rp_q[AW-1:0]];
    push = in_valid && in_ready && !flush;
    pop = out_valid && out_ready && !flush;
    wp_d = flush ? '0 : wp_q + (AW+1)'(push);
    rp_d = flush ? '0 : rp_q + (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Data words need no reset; they are only read while valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module hsc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h30,          // Arbitrary bus address
  parameter int RETRY_CYCLES = hsc_pkg::RETRY_CYC, // Retry wait in clocks
  parameter int FIFO_DEPTH = 8
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic RETRY,
  input wire logic [1:0] ON_PIN,
  input wire logic [1:0] CHANNEL_ENABLE_ONE,
  input wire logic [1:0] CHANNEL_ENABLE_TWO,
  input wire logic [1:0] FAULT_IN,
  input wire hsc_pkg::hsc_smp_t [3:0] SMP,
  output logic [1:0] GATE_ON,
  output logic [1:0] SHUT_OFF
);
  import hsc_pkg::*;

  // True for the four history block-read bases
  function automatic logic is_buf(input logic [7:0] a);
    is_buf = (a >= OFS_BUF0) && (a <= OFS_BUF3);
  endfunction

  // Configuration state
  logic [3:0] res_q, res_d;        // Resolution select, one bit per buffer
  logic [5:0] dly_q, dly_d;        // Stop delay in samples
  logic [7:0] key_q, key_d;        // Force-on key
  logic [1:0] force_q, force_d;    // Force-on bits
  logic retry_mode_q, retry_mode_d;
  logic init_q;                    // Set once the policy pin is caught
  // Channel state
  logic [1:0] off_q, off_d;        // Shut down by a fault
  logic [1:0] gate_q, gate_d;
  logic [31:0] tmr_q [2];
  logic [31:0] tmr_d [2];
  // History state
  logic [9:0] hist [4][50];
  logic [5:0] wp_q [4];
  logic [5:0] wp_d [4];
  logic [5:0] cnt_q [4];
  logic [5:0] cnt_d [4];
  logic [3:0] pend_q, pend_d;      // Shutdown seen, delay running
  logic [3:0] stop_q, stop_d;      // Storing halted
  logic [3:0] wr_en;
  // Read-out producer state
  logic [1:0] sel_q, sel_d;
  logic [5:0] ridx_q, ridx_d;
  logic [5:0] rn_q, rn_d;          // Samples already queued
  logic half_q, half_d;            // Low part of a full sample is next
  logic f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [7:0] f_in_data, f_out_data;
  logic [9:0] cur;
  // Register port state
  hsc_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d;          // Receive shifter
  logic [7:0] tx_q, tx_d;          // Transmit shifter
  logic [7:0] ptr_q, ptr_d;        // Register pointer
  logic [3:0] bit_q, bit_d;
  logic first_q, first_d;          // Next written byte is the pointer
  logic rw_q, rw_d;
  logic oe_n_q, oe_n_d;
  logic scl_q, sda_q, sda_out_q;
  logic wr_stb, buf_init;
  logic start, stop, rise, fall;
  logic [7:0] reg_rdata, nxt;
  logic req, frc;

  // Register writes; key gating on force bits
  always_comb begin
    res_d = res_q;
    dly_d = dly_q;
    key_d = key_q;
    force_d = force_q;
    retry_mode_d = init_q ? retry_mode_q : RETRY;
    if (wr_stb) begin
      case (ptr_q)
        OFS_RES: res_d = sh_q[3:0];
        OFS_DLY: dly_d = (sh_q[5:0] > DLY_MAX) ? DLY_MAX : sh_q[5:0];
        OFS_KEY: key_d = sh_q;
        OFS_FORCE: begin
          // Clearing is always allowed; setting only with the key in place
          force_d = (key_q == KEY_UNLOCK) ? sh_q[1:0] : (force_q & sh_q[1:0]);
        end
        default: ;
      endcase
    end
  end

  // Readable registers; unused bits come back as zero
  always_comb begin
    reg_rdata = 8'h00;
    case (ptr_q)
      OFS_RES: reg_rdata = {4'h0, res_q};
      OFS_DLY: reg_rdata = {2'h0, dly_q};
      OFS_KEY: reg_rdata = key_q;
      OFS_FORCE: reg_rdata = {6'h00, force_q};
      OFS_STAT3: reg_rdata[STAT3_RETRY_BIT] = retry_mode_q;
      default: ;
    endcase
  end

  // Policy pin is caught on the first edge after reset release
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      res_q <= RES_RST;
      dly_q <= DLY_RST;
      key_q <= KEY_RST;
      force_q <= FORCE_RST;
      retry_mode_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      res_q <= res_d;
      dly_q <= dly_d;
      key_q <= key_d;
      force_q <= force_d;
      retry_mode_q <= retry_mode_d;
      init_q <= 1'b1;
    end
  end

  // Channel enable, fault shutdown and restart policy
  always_comb begin
    req = 1'b0;
    frc = 1'b0;
    off_d = off_q;
    gate_d = gate_q;
    for (int c = 0; c < 2; c++) begin
      req = ON_PIN[c] & CHANNEL_ENABLE_ONE[c] & CHANNEL_ENABLE_TWO[c];
      frc = force_q[c] && (key_q == KEY_UNLOCK);
      tmr_d[c] = tmr_q[c];
      if (frc) begin
        off_d[c] = 1'b0;
      end else if (off_q[c]) begin
        if (retry_mode_q) begin
          // Retry attempt; a lasting fault trips again and rearms the wait
          if (tmr_q[c] >= 32'(RETRY_CYCLES - 1)) begin
            off_d[c] = 1'b0;
          end else begin
            tmr_d[c] = tmr_q[c] + 32'h0000_0001;
          end
        end else if (!req) begin
          off_d[c] = 1'b0;
        end
      end else if (FAULT_IN[c] && gate_q[c]) begin
        off_d[c] = 1'b1;
        tmr_d[c] = 32'h0000_0000;
      end
      gate_d[c] = frc | (req & !off_d[c]);
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      off_q <= 2'h0;
      gate_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        tmr_q[c] <= 32'h0000_0000;
      end
    end else begin
      off_q <= off_d;
      gate_q <= gate_d;
      for (int c = 0; c < 2; c++) begin
        tmr_q[c] <= tmr_d[c];
      end
    end
  end

  // History recording with the stop delay counted in conversions
  always_comb begin
    pend_d = pend_q;
    stop_d = stop_q;
    wr_en = 4'h0;
    for (int b = 0; b < 4; b++) begin
      wp_d[b] = wp_q[b];
      cnt_d[b] = cnt_q[b];
      if (!off_q[b/2]) begin
        // Channel back up: recording runs again
        pend_d[b] = 1'b0;
        stop_d[b] = 1'b0;
      end else if (!pend_q[b] && !stop_q[b]) begin
        pend_d[b] = 1'b1;
        cnt_d[b] = dly_q;
      end
      if (SMP[b].valid && !stop_q[b]) begin
        if (pend_q[b] && off_q[b/2] && (cnt_q[b] == 6'h00)) begin
          stop_d[b] = 1'b1;
        end else begin
          wr_en[b] = 1'b1;
          wp_d[b] = (wp_q[b] == HIST_LAST) ? 6'h00 : wp_q[b] + 6'h01;
          if (pend_q[b] && off_q[b/2]) begin
            cnt_d[b] = cnt_q[b] - 6'h01;
          end
        end
      end
    end
  end

  // Samples are kept in flops so a read-out before the first fill is defined
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_q <= 4'h0;
      stop_q <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        wp_q[b] <= 6'h00;
        cnt_q[b] <= 6'h00;
        for (int i = 0; i < 50; i++) begin
          hist[b][i] <= 10'h000;
        end
      end
    end else begin
      pend_q <= pend_d;
      stop_q <= stop_d;
      for (int b = 0; b < 4; b++) begin
        wp_q[b] <= wp_d[b];
        cnt_q[b] <= cnt_d[b];
        if (wr_en[b]) begin
          hist[b][wp_q[b]] <= SMP[b].data;
        end
      end
    end
  end

  // Read-out producer: oldest sample first, formatted into the FIFO
  always_comb begin
    sel_d = sel_q;
    ridx_d = ridx_q;
    rn_d = rn_q;
    half_d = half_q;
    cur = hist[sel_q][ridx_q];
    f_in_valid = (rn_q < HIST_LEN) && !buf_init;
    // High byte first, then the two LSBs in the low bits
    f_in_data = (res_q[sel_q] || !half_q) ? cur[9:2] : {6'h00, cur[1:0]};
    if (buf_init) begin
      sel_d = 2'(sh_q - OFS_BUF0);
      ridx_d = wp_q[2'(sh_q - OFS_BUF0)];
      rn_d = 6'h00;
      half_d = 1'b0;
    end else if (f_in_valid && f_in_ready) begin
      if (res_q[sel_q] || half_q) begin
        ridx_d = (ridx_q == HIST_LAST) ? 6'h00 : ridx_q + 6'h01;
        rn_d = rn_q + 6'h01;
        half_d = 1'b0;
      end else begin
        half_d = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_q <= 2'h0;
      ridx_q <= 6'h00;
      rn_q <= HIST_LEN;
      half_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      ridx_q <= ridx_d;
      rn_q <= rn_d;
      half_q <= half_d;
    end
  end

  // Prefetch buffer so the port never waits on formatting
  hsc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst_n(RESETN),
    .flush(buf_init),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  // Two-wire register port: address, pointer, writes and block reads
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    bit_d = bit_q;
    first_d = first_q;
    rw_d = rw_q;
    oe_n_d = oe_n_q;
    wr_stb = 1'b0;
    buf_init = 1'b0;
    f_pop = 1'b0;
    start = scl_q && SCL && sda_q && !SDA_IN;
    stop = scl_q && SCL && !sda_q && SDA_IN;
    rise = SCL && !scl_q;
    fall = !SCL && scl_q;
    // An empty stream answers all ones
    nxt = is_buf(ptr_q) ? (f_out_valid ? f_out_data : 8'hff) : reg_rdata;
    if (start) begin
      st_d = ST_ADDR;
      bit_d = 4'h0;
      oe_n_d = 1'b1;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        ST_ADDR, ST_WR: begin
          if (rise && (bit_q != 4'h8)) begin
            sh_d = {sh_q[6:0], SDA_IN};
            bit_d = bit_q + 4'h1;
          end else if (fall && (bit_q == 4'h8)) begin
            if (st_q == ST_ADDR) begin
              first_d = 1'b1;
              rw_d = sh_q[0];
              st_d = (sh_q[7:1] == DEV_ADDR) ? ST_ACK_A : ST_IDLE;
              oe_n_d = (sh_q[7:1] != DEV_ADDR);
            end else begin
              oe_n_d = 1'b0;
              st_d = ST_ACK_W;
              if (first_q) begin
                ptr_d = sh_q;
                buf_init = is_buf(sh_q);
              end else begin
                wr_stb = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        ST_ACK_W: begin
          if (fall) begin
            oe_n_d = 1'b1;
            bit_d = 4'h0;
            first_d = 1'b0;
            st_d = ST_WR;
          end
        end
        ST_ACK_A, ST_ACK_R: begin
          if (rise && (st_q == ST_ACK_R) && SDA_IN) begin
            st_d = ST_IDLE;
          end else if (fall && ((st_q == ST_ACK_R) || rw_q)) begin
            // Load next byte and drive its top bit at once
            tx_d = nxt;
            oe_n_d = nxt[7];
            bit_d = 4'h0;
            st_d = ST_RD;
            if (is_buf(ptr_q)) begin
              f_pop = 1'b1;
            end else begin
              ptr_d = ptr_q + 8'h01;
            end
          end else if (fall) begin
            oe_n_d = 1'b1;
            bit_d = 4'h0;
            st_d = ST_WR;
          end
        end
        ST_RD: begin
          if (rise && (bit_q != 4'h8)) begin
            bit_d = bit_q + 4'h1;
          end else if (fall && (bit_q == 4'h8)) begin
            oe_n_d = 1'b1;
            st_d = ST_ACK_R;
          end else if (fall) begin
            tx_d = {tx_q[6:0], 1'b1};
            oe_n_d = tx_q[6];
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      ptr_q <= 8'h00;
      bit_q <= 4'h0;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      oe_n_q <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      bit_q <= bit_d;
      first_q <= first_d;
      rw_q <= rw_d;
      oe_n_q <= oe_n_d;
      scl_q <= SCL;
      sda_q <= SDA_IN;
      sda_out_q <= 1'b0;
    end
  end

  assign SDA_OUT = sda_out_q;
  assign SDA_OE_N = oe_n_q;
  assign GATE_ON = gate_q;
  assign SHUT_OFF = off_q;
endmodule

`default_nettype wire

//--- hsc_top_assertions.sv
// Port-level checks of the restart policy and data line of the capture block.
// Assumes the policy pin is captured at the first clock after reset.
`timescale 1ns/1ns
`default_nettype none
module hsc_top_assertions #(
  parameter int RETRY_CYCLES = 50
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic SCL,
  input wire logic SDA_OE_N,
  input wire logic SDA_OUT,
  input wire logic RETRY,
  input wire logic [1:0] ON_PIN,
  input wire logic [1:0] CHANNEL_ENABLE_ONE,
  input wire logic [1:0] CHANNEL_ENABLE_TWO,
  input wire logic [1:0] FAULT_IN,
  input wire logic [1:0] GATE_ON,
  input wire logic [1:0] SHUT_OFF
);
  import hsc_pkg::*;
  logic first_q, first_d; // First clock after reset
  logic retry_q, retry_d; // Captured policy
  int cnt_q, cnt_d; // Clocks spent in shutdown, channel 0
  logic [1:0] req; // Channel request from pin and enables
  assign req = ON_PIN & CHANNEL_ENABLE_ONE & CHANNEL_ENABLE_TWO;
  // Next values of the helper state
  always_comb begin
    first_d = 1'b0;
    retry_d = first_q ? RETRY : retry_q;
    cnt_d = SHUT_OFF[0] ? cnt_q + 1 : 0;
  end
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      first_q <= 1'b1;
      retry_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      first_q <= first_d;
      retry_q <= retry_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  trip_cause_a: assert property ($rose(SHUT_OFF[0]) |-> $past(FAULT_IN[0]) && $past(GATE_ON[0]))
    else $error("shutdown without fault on channel 0");
  trip_cause1_a: assert property (!$past(FAULT_IN[1]) && !$past(SHUT_OFF[1]) |-> !SHUT_OFF[1])
    else $error("shutdown without fault on channel 1");
  shut_gate_a: assert property ((SHUT_OFF & GATE_ON) == 2'h0)
    else $error("gate on during shutdown");
  latched_hold_a: assert property (!retry_q && SHUT_OFF[0] && req[0] |=> SHUT_OFF[0])
    else $error("latched shutdown released");
  latched_clear_a: assert property (!retry_q && SHUT_OFF[1] && !req[1] |-> ##[1:2] !SHUT_OFF[1])
    else $error("latched shutdown not cleared by toggle");
  retry_exact_a: assert property (retry_q && $fell(SHUT_OFF[0]) |-> $past(cnt_q) == RETRY_CYCLES - 1)
    else $error("retry wait length wrong");
  retry_bound_a: assert property (retry_q && SHUT_OFF[0] |-> cnt_q < RETRY_CYCLES)
    else $error("retry wait overran");
  // The device may only move the data line while the clock is low, else it fakes a start or stop
  sda_od_a: assert property ($changed(SDA_OE_N) |-> !$past(SCL) && (SDA_OUT == 1'b0))
    else $error("data line moved while clock high or driven high");
  cover property (retry_q && $rose(SHUT_OFF[0]));
  cover property (!retry_q && $fell(SHUT_OFF[1]));
  cover property (GATE_ON[0] && FAULT_IN[0]);
endmodule
bind hsc_top hsc_top_assertions #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (.MCLK(MCLK), .RESETN(RESETN),
  .SCL(SCL), .SDA_OE_N(SDA_OE_N),
  .SDA_OUT(SDA_OUT), .RETRY(RETRY), .ON_PIN(ON_PIN), .CHANNEL_ENABLE_ONE(CHANNEL_ENABLE_ONE),
  .CHANNEL_ENABLE_TWO(CHANNEL_ENABLE_TWO), .FAULT_IN(FAULT_IN), .GATE_ON(GATE_ON), .SHUT_OFF(SHUT_OFF));
`default_nettype wire

//--- hsc_top_tb.sv
// Self-checking bench of the capture block with a queue model of the history buffers.
// Assumes the host model in hsc_host and a pull-up on SDA.
`timescale 1ns/1ns
`default_nettype none
module hsc_top_tb;
  import hsc_pkg::*;
  localparam int RC = 50; // Short retry wait
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic retry = 1'b0;
  logic [1:0] on_pin = 2'h3;
  logic [1:0] en1 = 2'h3;
  logic [1:0] en2 = 2'h3;
  logic [1:0] flt = 2'h0;
  hsc_smp_t [3:0] smp = '0;
  wire logic scl, sda_rel, sda_out, oe_n, sda;
  wire logic [1:0] gate, shut;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h18e2_bf44;
  int dly = 25; // Model of the stop delay
  int hist[4][$]; // Model of the four buffers
  int stopn[2] = '{-1, -1}; // Samples still to store; -1 running
  assign sda = sda_rel & (oe_n | sda_out); // Pull-up wins unless the host or the device pulls
  always #20 mclk = ~mclk;
  hsc_top #(.RETRY_CYCLES(RC)) dut (.MCLK(mclk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(oe_n), .RETRY(retry), .ON_PIN(on_pin), .CHANNEL_ENABLE_ONE(en1),
    .CHANNEL_ENABLE_TWO(en2), .FAULT_IN(flt), .SMP(smp), .GATE_ON(gate), .SHUT_OFF(shut));
  hsc_host host (.clk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd1(input logic [7:0] p, input logic [7:0] e);
    host.rd(p, 1);
    chk(host.got[0], e);
  endtask
  task automatic endt(input string s);
    $display("test %s done, %0d mismatches", s, n_mismatch);
  endtask
  // Reset held four clocks with the policy pin at r
  task automatic do_reset(input logic r);
    resetn = 1'b0;
    retry = r;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  // One-clock conversion pulses on all four signals, mirrored in the model
  task automatic feed(input int n);
    logic [9:0] v;
    repeat (n) begin
      @(negedge mclk);
      for (int s = 0; s < 4; s++) begin
        v = 10'($random(seed));
        smp[s].valid = 1'b1;
        smp[s].data = v;
        if (stopn[s / 2] != 0) begin
          hist[s].push_back(v);
          if (hist[s].size() > 50) void'(hist[s].pop_front());
          if (stopn[s / 2] > 0 && s % 2 == 1) stopn[s / 2]--;
        end
      end
      @(negedge mclk);
      smp = '0;
    end
  endtask
  // Fault pulse on channel c; shutdown must land at the next edge
  task automatic trip(input int c);
    @(negedge mclk);
    flt[c] = 1'b1;
    @(negedge mclk);
    flt[c] = 1'b0;
    stopn[c] = dly;
    chk(8'(shut[c]), 8'h01);
    chk(8'(gate[c]), 8'h00);
  endtask
  // Whole buffer b plus one byte past its end
  task automatic readbuf(input int b, input logic full);
    int n;
    logic [9:0] v;
    n = full ? 100 : 50;
    host.rd(8'h46 + 8'(b), n + 1);
    for (int k = 0; k < 50; k++) begin
      v = 10'(hist[b][k]);
      if (full) begin
        chk(host.got[2 * k], v[9:2]);
        chk(host.got[2 * k + 1], {6'h0, v[1:0]});
      end else begin
        chk(host.got[k], v[9:2]);
      end
    end
    chk(host.got[n], 8'hff);
  endtask
  // Length of one shutdown of channel 0, bounded waits
  task automatic shutlen();
    int k;
    k = 0;
    while (shut[0] !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    k = 0;
    while (shut[0] === 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    chk(8'(k), 8'(RC));
  endtask
  // Cut a hung run short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      tally_and_finish();
    end
  end
  initial begin
    do_reset(1'b0);
    rd1(8'h3a, 8'h00);
    rd1(8'h3f, 8'h0f);
    rd1(8'h40, 8'h19);
    rd1(8'h39, 8'h00);
    rd1(8'h34, 8'h00);
    host.wr(8'h20, 8'h5a);
    rd1(8'h20, 8'h00);
    endt("reset_values");
    host.wr(8'h40, 8'hff);
    rd1(8'h40, 8'h32);
    endt("stop_delay_clamp");
    host.wr(8'h3a, 8'h03);
    rd1(8'h3a, 8'h00);
    host.wr(8'h39, 8'ha5);
    host.wr(8'h3a, 8'hff);
    rd1(8'h3a, 8'h03);
    on_pin = 2'h0;
    flt = 2'h3;
    repeat (4) @(negedge mclk);
    chk({4'h0, gate, shut}, 8'h0c);
    flt = 2'h0;
    on_pin = 2'h3;
    host.wr(8'h3a, 8'h00);
    host.wr(8'h39, 8'h00);
    endt("force_on");
    host.wr(8'h3f, 8'h0a);
    rd1(8'h3f, 8'h0a);
    feed(60);
    host.wr(8'h40, 8'h03);
    dly = 3;
    trip(0);
    host.wr(8'h40, 8'h00);
    dly = 0;
    trip(1);
    feed(10);
    for (int b = 0; b < 4; b++) readbuf(b, b % 2 == 0);
    endt("history");
    chk({6'h0, shut}, 8'h03);
    on_pin[0] = 1'b0;
    en2[1] = 1'b0;
    repeat (3) @(negedge mclk);
    chk({4'h0, gate, shut}, 8'h00);
    on_pin[0] = 1'b1;
    en2[1] = 1'b1;
    repeat (3) @(negedge mclk);
    chk({4'h0, gate, shut}, 8'h0c);
    endt("latched_off");
    do_reset(1'b1);
    retry = 1'b0;
    rd1(8'h34, 8'h40);
    flt[0] = 1'b1;
    for (int i = 0; i < 2; i++) shutlen();
    flt[0] = 1'b0;
    repeat (RC + 4) @(negedge mclk);
    chk({4'h0, gate, shut}, 8'h0c);
    endt("auto_retry");
    tally_and_finish();
  end
endmodule
`default_nettype wire
